/* File: logic/opc_line_control.v */
// Register file and line control of the OTG power and termination logic.
// Assumes a byte register port from serial interface logic outside; line senses are synchronous.
`timescale 1ns/100ps
`include "otg_pwr_regs.vh"
module opc_line_control #(
	parameter [24:0] PULSE_CYC = `OPC_PULSE_CYC,
	parameter [22:0] CONNECT_CYC = `OPC_CONNECT_CYC,
	parameter [22:0] SETTLE_CYC = `OPC_SETTLE_CYC
) (
	input wire sys_clk,
	input wire rst,
	input wire regWrite,
	input wire regRead,
	input wire [7:0] regAddr,
	input wire [7:0] regWdata,
	output reg [7:0] regRdata,
	output reg regAck,
	input wire roleIdInput,
	input wire plusLineHigh,
	input wire minusLineHigh,
	input wire vbusValid,
	input wire sessionValid,
	input wire sessionEnd,
	output reg roleIdOutput,
	output reg shutdownOut,
	output reg comparatorEnable,
	output reg currentSource,
	output reg pumpDrive,
	output reg busDrain,
	output reg pullupSwitchPlus,
	output reg pullupSwitchMinus,
	output reg pulldownPlus,
	output reg pulldownMinus,
	output reg se0Drive,
	output reg irqN
);
	reg [7:0] busPowerControl;
	reg [7:0] lineTerminationControl;
	reg [7:0] irqEnable;
	reg aSideFlag;
	reg bSideFlag;
	reg aSideLatch;
	reg autoPullup;
	reg autoSe0;
	wire pulseOn;
	wire shutdown = busPowerControl[`OPC_POWER_DOWN_BIT];
	wire autoEn = busPowerControl[`OPC_AUTO_HANDOVER_BIT];
	wire plusPullupBit = lineTerminationControl[`OPC_PULLUP_PLUS_BIT];
	wire aActive = !roleIdInput && autoEn && !shutdown;
	wire bActive = roleIdInput && autoEn && !shutdown;
	wire lineSe0 = !plusLineHigh && !minusLineHigh;
	wire connectDue;
	wire settled;
	wire aConnectEvent = aActive && connectDue && !autoPullup;
	wire latchRead = regRead && regAddr == `OPC_ADDR_LATCH;
	wire plusPull = plusPullupBit || autoPullup;

	opc_pulse_timer #(
		.PULSE_CYC(PULSE_CYC)
	) pulseTimer (
		.sys_clk(sys_clk),
		.rst(rst),
		.request(busPowerControl[`OPC_TIMED_PULSE_BIT]),
		.shutdown(shutdown),
		.pulseOn(pulseOn)
	);

	// The connect delay counts from the first SE0 cycle; the pullup switch closes two edges after done rises.
	opc_wait_timer #(
		.LIMIT(CONNECT_CYC)
	) connectTimer (
		.sys_clk(sys_clk),
		.rst(rst),
		.run(aActive && lineSe0),
		.done(connectDue)
	);

	// The settle wait restarts whenever our own pullup is on or the feature is off.
	opc_wait_timer #(
		.LIMIT(SETTLE_CYC)
	) settleTimer (
		.sys_clk(sys_clk),
		.rst(rst),
		.run(bActive && !plusPullupBit),
		.done(settled)
	);

	always @(posedge sys_clk) begin
		if (rst) begin
			busPowerControl <= `OPC_RESET_BYTE;
			lineTerminationControl <= `OPC_RESET_BYTE;
			irqEnable <= `OPC_RESET_BYTE;
		end else if (regWrite) begin
			// Register writes stay live in shutdown.
			case (regAddr)
				`OPC_ADDR_TERM: begin
					lineTerminationControl <= regWdata;
				end
				`OPC_ADDR_POWER: begin
					busPowerControl <= regWdata;
				end
				`OPC_ADDR_IRQEN: begin
					irqEnable <= regWdata;
				end
				default: begin
					busPowerControl <= busPowerControl;
				end
			endcase
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			autoPullup <= 1'b0;
			aSideFlag <= 1'b0;
			autoSe0 <= 1'b0;
			bSideFlag <= 1'b0;
		end else begin
			if (!aActive) begin
				autoPullup <= 1'b0;
			end else if (connectDue) begin
				autoPullup <= 1'b1;
			end
			if (aConnectEvent) begin
				aSideFlag <= 1'b1;
			end else if (!autoEn) begin
				aSideFlag <= 1'b0;
			end
			if (!bActive) begin
				autoSe0 <= 1'b0;
			end else if (settled && plusLineHigh) begin
				autoSe0 <= 1'b1;
			end
			if (bActive && settled && plusLineHigh && !autoSe0) begin
				bSideFlag <= 1'b1;
			end else if (!autoEn) begin
				bSideFlag <= 1'b0;
			end
		end
	end

	// The latch set wins over the clear by read.
	always @(posedge sys_clk) begin
		if (rst) begin
			aSideLatch <= 1'b0;
		end else if (aConnectEvent && irqEnable[`OPC_A_IRQ_EN_BIT]) begin
			aSideLatch <= 1'b1;
		end else if (latchRead) begin
			aSideLatch <= 1'b0;
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			regRdata <= 8'h00;
			regAck <= 1'b0;
		end else begin
			regAck <= regRead || regWrite;
			if (regRead) begin
				case (regAddr)
					`OPC_ADDR_TERM: begin
						regRdata <= lineTerminationControl;
					end
					`OPC_ADDR_POWER: begin
						regRdata <= busPowerControl;
					end
					`OPC_ADDR_STATUS: begin
						regRdata <= {2'b00, bSideFlag, aSideFlag, roleIdInput,
							sessionEnd && !shutdown, sessionValid && !shutdown,
							vbusValid && !shutdown};
					end
					`OPC_ADDR_LATCH: begin
						regRdata <= {7'h00, aSideLatch};
					end
					`OPC_ADDR_IRQEN: begin
						regRdata <= irqEnable;
					end
					default: begin
						regRdata <= 8'h00;
					end
				endcase
			end
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			roleIdOutput <= 1'b1;
			shutdownOut <= 1'b0;
			comparatorEnable <= 1'b0;
			currentSource <= 1'b0;
			pumpDrive <= 1'b0;
			busDrain <= 1'b0;
			pullupSwitchPlus <= 1'b0;
			pullupSwitchMinus <= 1'b0;
			pulldownPlus <= 1'b0;
			pulldownMinus <= 1'b0;
			se0Drive <= 1'b0;
			irqN <= 1'b1;
		end else begin
			roleIdOutput <= roleIdInput;
			shutdownOut <= shutdown;
			comparatorEnable <= !shutdown;
			currentSource <= !shutdown && (pulseOn ||
				busPowerControl[`OPC_CONT_CHARGE_BIT]);
			pumpDrive <= !shutdown && busPowerControl[`OPC_PUMP_DRIVE_BIT];
			busDrain <= busPowerControl[`OPC_BUS_DRAIN_BIT];
			pullupSwitchPlus <= plusPull;
			pullupSwitchMinus <= !plusPull &&
				lineTerminationControl[`OPC_PULLUP_MINUS_BIT];
			pulldownPlus <= lineTerminationControl[`OPC_PULLDOWN_PLUS_BIT];
			pulldownMinus <= lineTerminationControl[`OPC_PULLDOWN_MINUS_BIT];
			se0Drive <= autoSe0;
			irqN <= !aSideLatch;
		end
	end
endmodule

/* File: logic/opc_pulse_timer.v */
// Self-timed session request pulse of the bus current source.
// Assumes level request bit from the register file and a shutdown level.
`timescale 1ns/100ps
`include "otg_pwr_regs.vh"
module opc_pulse_timer #(
	parameter [24:0] PULSE_CYC = `OPC_PULSE_CYC
) (
	input wire sys_clk,
	input wire rst,
	input wire request,
	input wire shutdown,
	output reg pulseOn
);
	reg [24:0] count;
	reg spent;
	always @(posedge sys_clk) begin
		if (rst || shutdown) begin
			count <= 25'h000_0000;
			pulseOn <= 1'b0;
			spent <= 1'b0;
		end else if (!request) begin
			count <= 25'h000_0000;
			pulseOn <= 1'b0;
			spent <= 1'b0;
		end else if (!spent) begin
			pulseOn <= 1'b1;
			spent <= 1'b1;
			count <= 25'h000_0000;
		end else if (pulseOn) begin
			// Counting from the first on cycle keeps the pulse no longer than the bound.
			if (count == PULSE_CYC - 25'h000_0002) begin
				pulseOn <= 1'b0;
			end else begin
				count <= count + 25'h000_0001;
			end
		end
	end
endmodule

/* File: logic/opc_wait_timer.v */
// Retriggerable wait counter: done rises once the condition has stood for LIMIT cycles.
// Assumes the condition is already synchronous to sys_clk.
`timescale 1ns/100ps
module opc_wait_timer #(
	parameter [22:0] LIMIT = 23'h000_0001
) (
	input wire sys_clk,
	input wire rst,
	input wire run,
	output reg done
);
	reg [22:0] count;
	always @(posedge sys_clk) begin
		if (rst || !run) begin
			count <= 23'h000_0000;
			done <= 1'b0;
		end else if (count >= LIMIT - 23'h000_0001) begin
			done <= 1'b1;
		end else begin
			count <= count + 23'h000_0001;
		end
	end
endmodule

/* File: logic/otg_pwr_regs.vh */
// Register offsets, field positions, reset values and timing counts for the power line control.
// Assumes a 200 MHz sys_clk and byte-wide register access from the serial port logic.
`ifndef OTG_PWR_REGS_VH
`define OTG_PWR_REGS_VH
`define OPC_ADDR_TERM 8'h10
`define OPC_ADDR_POWER 8'h11
`define OPC_ADDR_STATUS 8'h13
`define OPC_ADDR_LATCH 8'h14
`define OPC_ADDR_IRQEN 8'h15
`define OPC_POWER_DOWN_BIT 0
`define OPC_TIMED_PULSE_BIT 1
`define OPC_CONT_CHARGE_BIT 2
`define OPC_PUMP_DRIVE_BIT 3
`define OPC_BUS_DRAIN_BIT 4
`define OPC_AUTO_HANDOVER_BIT 5
`define OPC_PULLUP_PLUS_BIT 4
`define OPC_PULLUP_MINUS_BIT 5
`define OPC_PULLDOWN_PLUS_BIT 6
`define OPC_PULLDOWN_MINUS_BIT 7
`define OPC_A_FLAG_BIT 4
`define OPC_B_FLAG_BIT 5
`define OPC_ROLE_BIT 3
`define OPC_A_IRQ_EN_BIT 0
`define OPC_RESET_BYTE 8'h00
`define OPC_CLK_MHZ 200
`define OPC_CONNECT_MS 3
// Sized so that they meet the 23 and 25 bit timer parameters without truncation.
// Three milliseconds at 200 MHz, less one cycle.
`define OPC_CONNECT_CYC 23'h09_27BF
`define OPC_SETTLE_US 25
`define OPC_SETTLE_CYC 23'h1388
`define OPC_PULSE_MS 90
`define OPC_PULSE_CYC 25'h112_A880
`endif

/* File: verification/opc_chk_checker.sv */
// Port checker of the power line control.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
`include "otg_pwr_regs.vh"
module opc_chk (
	input wire sys_clk,
	input wire rst,
	input wire regWrite,
	input wire regRead,
	input wire [7:0] regAddr,
	input wire [7:0] regWdata,
	input wire roleIdInput,
	input wire roleIdOutput,
	input wire shutdownOut,
	input wire comparatorEnable,
	input wire currentSource,
	input wire pumpDrive,
	input wire busDrain,
	input wire pullupSwitchPlus,
	input wire pullupSwitchMinus,
	input wire se0Drive,
	input wire irqN
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire pwrWr = regWrite && regAddr == `OPC_ADDR_POWER;
	wire latchRd = regRead && regAddr == `OPC_ADDR_LATCH;
	property p_comp; !$past(rst) |-> comparatorEnable != shutdownOut; endproperty
	a_comp: assert property (p_comp) else $error("comparator enable wrong");
	property p_sdoff;
		shutdownOut && $past(shutdownOut) |-> !currentSource && !se0Drive && !pumpDrive;
	endproperty
	a_sdoff: assert property (p_sdoff) else $error("drive active in shutdown");
	property p_cross; !(pullupSwitchPlus && pullupSwitchMinus); endproperty
	a_cross: assert property (p_cross) else $error("both pullups on");
	property p_irq; $fell(irqN) |-> ##[0:1] pullupSwitchPlus; endproperty
	a_irq: assert property (p_irq) else $error("interrupt without pullup");
	property p_hold; !irqN && !latchRd && !$past(latchRd) |=> !irqN; endproperty
	a_hold: assert property (p_hold) else $error("interrupt dropped unread");
	property p_role; !$past(rst) |-> roleIdOutput == $past(roleIdInput); endproperty
	a_role: assert property (p_role) else $error("role output wrong");
	// The register takes the write on one edge and the output follows on the next.
	property p_drain;
		$changed(busDrain) |-> $past(pwrWr, 2) && busDrain == $past(regWdata[4], 2);
	endproperty
	a_drain: assert property (p_drain) else $error("drain change unexpected");
	property p_pump; $changed(pumpDrive) |-> $past(pwrWr, 2); endproperty
	a_pump: assert property (p_pump) else $error("pump change unexpected");
	c_irq: cover property ($fell(irqN));
	c_se0: cover property ($rose(se0Drive));
	c_pulse: cover property ($fell(currentSource));
endmodule
bind opc_line_control opc_chk chk_u (.*);

/* File: verification/opc_line_control_tb.sv */
// Self-checking bench of the power line control with a cable peer model.
// Assumes short timing parameters so pulse and handover waits stay brief.
`timescale 1ns/100ps
`include "otg_pwr_regs.vh"
module opc_line_control_tb;
	localparam int PULSE = 50;
	localparam int CONN = 20;
	localparam int SETTLE = 10;
	logic sysClk = 0;
	logic rst = 1;
	logic regWrite = 0;
	logic regRead = 0;
	logic roleIdInput = 1;
	logic vbusValid = 0;
	logic sessionValid = 0;
	logic sessionEnd = 0;
	logic [1:0] peerMode = 0;
	logic [7:0] regAddr = 0;
	logic [7:0] regWdata = 0;
	logic [7:0] pw = 0;
	logic [7:0] tm = 0;
	wire [7:0] regRdata;
	wire plusLineHigh, minusLineHigh, regAck, roleIdOutput, shutdownOut, comparatorEnable;
	wire currentSource, pumpDrive, busDrain, pullupSwitchPlus, pullupSwitchMinus;
	wire pulldownPlus, pulldownMinus, se0Drive, irqN;
	int n_fail = 0;
	int samples_checked = 0;
	int n;
	always #2.5 sysClk = !sysClk;
	opc_line_control #(.PULSE_CYC(25'd50), .CONNECT_CYC(23'd20), .SETTLE_CYC(23'd10)) dut_u (
		.sys_clk(sysClk), .*);
	opc_usb_peer peer_u (.peerMode(peerMode), .pullPlus(pullupSwitchPlus), .se0Drive(se0Drive),
		.plusLineHigh(plusLineHigh), .minusLineHigh(minusLineHigh));
	task automatic end_sim;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge sysClk);
		regWrite = w;
		regRead = !w;
		regAddr = a;
		regWdata = d;
		if (w && a == `OPC_ADDR_TERM) tm = d;
		if (w && a == `OPC_ADDR_POWER) pw = d;
		@(negedge sysClk);
		cmp({7'h0, regAck}, 8'h01);
		regWrite = 0;
		regRead = 0;
		@(negedge sysClk);
	endtask
	task automatic chkOut;
		cmp({pumpDrive, busDrain, shutdownOut, comparatorEnable, pulldownMinus, pulldownPlus,
			pullupSwitchMinus, pullupSwitchPlus}, {pw[3] & !pw[0], pw[4], pw[0], !pw[0],
			tm[7], tm[6], tm[5] & !tm[4], tm[4]});
		cmp({7'h0, currentSource}, {7'h0, pw[2] & !pw[0]});
	endtask
	// A wait that runs out is counted as a failure and ends the run.
	task automatic waitFor(input int sel, input int lim);
		n = 0;
		while ((sel == 0 ? currentSource : sel == 1 ? pullupSwitchPlus : se0Drive) !== 1'b1) begin
			@(negedge sysClk);
			n++;
			if (n > lim) begin
				cmp(8'h01, 8'h00);
				end_sim;
			end
		end
	endtask
	initial begin
		n = $urandom(13);
		repeat (20) @(negedge sysClk);
		rst = 0;
		cmp({6'h0, irqN, roleIdOutput}, 8'h03);
		acc(0, `OPC_ADDR_POWER, 0);
		cmp(regRdata, 8'h00);
		repeat (40) begin
			{sessionEnd, sessionValid, vbusValid} = 3'($urandom);
			acc(1, `OPC_ADDR_TERM, 8'($urandom));
			acc(1, `OPC_ADDR_POWER, 8'($urandom) & 8'h1d);
			chkOut;
			acc(0, `OPC_ADDR_POWER, 0);
			cmp(regRdata, pw);
			acc(0, `OPC_ADDR_STATUS, 0);
			cmp(regRdata, {4'h0, roleIdInput, pw[0] ? 3'h0 : {sessionEnd, sessionValid, vbusValid}});
		end
		acc(1, 8'h12, 8'hff);
		acc(0, 8'h12, 0);
		cmp(regRdata, 8'h00);
		acc(1, `OPC_ADDR_POWER, 8'h02);
		waitFor(0, 5);
		n = 0;
		while (currentSource === 1'b1 && n < 200) begin
			@(negedge sysClk);
			n++;
		end
		cmp({7'h0, n <= PULSE && n > PULSE - 3}, 8'h01);
		repeat (10) @(negedge sysClk);
		cmp({7'h0, currentSource}, 8'h00);
		acc(1, `OPC_ADDR_POWER, 0);
		acc(1, `OPC_ADDR_POWER, 8'h02);
		waitFor(0, 5);
		acc(1, `OPC_ADDR_POWER, 8'h03);
		chkOut;
		roleIdInput = 0;
		acc(1, `OPC_ADDR_TERM, 0);
		acc(1, `OPC_ADDR_IRQEN, 8'h01);
		acc(1, `OPC_ADDR_POWER, 8'h20);
		peerMode = 1;
		waitFor(1, CONN + 4);
		cmp({7'h0, irqN}, 8'h00);
		acc(0, `OPC_ADDR_STATUS, 0);
		cmp(regRdata & 8'h10, 8'h10);
		cmp({7'h0, irqN}, 8'h00);
		acc(0, `OPC_ADDR_LATCH, 0);
		cmp({6'h0, regRdata[0], irqN}, 8'h03);
		acc(1, `OPC_ADDR_TERM, 8'h10);
		acc(1, `OPC_ADDR_POWER, 0);
		chkOut;
		roleIdInput = 1;
		peerMode = 2;
		acc(1, `OPC_ADDR_POWER, 8'h20);
		acc(1, `OPC_ADDR_TERM, 0);
		waitFor(2, SETTLE + 10);
		cmp({7'h0, n + 2 >= SETTLE}, 8'h01);
		acc(0, `OPC_ADDR_STATUS, 0);
		cmp(regRdata & 8'h38, 8'h28);
		acc(1, `OPC_ADDR_POWER, 0);
		// The SE0 driver drops one cycle later than the plain register outputs.
		@(negedge sysClk);
		cmp({7'h0, se0Drive}, 8'h00);
		roleIdInput = 0;
		peerMode = 1;
		acc(1, `OPC_ADDR_POWER, 8'h21);
		repeat (CONN + 10) @(negedge sysClk);
		cmp({7'h0, pullupSwitchPlus}, 8'h00);
		end_sim;
	end
endmodule

/* File: verification/opc_usb_peer.sv */
// Cable peer model for the two data lines.
// Assumes the bench sets the peer state off the clock edge.
`timescale 1ns/100ps
module opc_usb_peer (
	input wire [1:0] peerMode,
	input wire pullPlus,
	input wire se0Drive,
	output wire plusLineHigh,
	output wire minusLineHigh
);
	// Modes: 0 idle, 1 SE0, 2 peer plus pullup, 3 minus high. Device SE0 wins over all.
	assign plusLineHigh = !se0Drive && (pullPlus || !peerMode[0]);
	assign minusLineHigh = !se0Drive && peerMode == 2'h3;
endmodule
